//--- hw/pvc_pkg.sv
package pvc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_TRIM   = 8'h59;  // Oscillator trim code
  localparam logic [7:0] ADDR_HOLD   = 8'h5C;  // Synthesizer PLL hold
  localparam logic [7:0] ADDR_TCTRL  = 8'h5D;  // Oscillator tune control
  localparam logic [7:0] ADDR_TSTAT  = 8'h5E;  // Oscillator tune status
  localparam logic [7:0] ADDR_CALRUN = 8'h61;  // Converter calibration run

  // ****************************************
  // Field positions and widths
  // ****************************************
  localparam int TRIM_LSB    = 0;  // Trim code low bit
  localparam int TRIM_W      = 7;  // Trim code width
  localparam int HOLD_BIT    = 0;  // PLL hold bit
  localparam int TUNE_EN_BIT = 0;  // Tune enable bit
  localparam int SETTLE_LSB  = 4;  // Settle select low bit
  localparam int SETTLE_W    = 3;  // Settle select width
  localparam int DONE_BIT    = 0;  // Tune complete bit
  localparam int CALRUN_BIT  = 0;  // Calibration run bit

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic                HOLD_RST    = 1'b0;   // Hold released
  localparam logic                TUNE_EN_RST = 1'b0;   // Tuning off
  localparam logic [SETTLE_W-1:0] SETTLE_RST  = 3'h4;   // Middle settle time
  localparam logic                CALRUN_RST  = 1'b1;   // Calibration runs
  localparam logic [TRIM_W-1:0]   TRIM_RST    = 7'h00;  // Trim field reset
  localparam logic [7:0]          RDATA_RST   = 8'h00;  // Read data idle

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS   = 4;   // System clock period
  localparam int SETTLE_BASE_NS  = 64;  // Settle time at select 0
  localparam int SETTLE_BASE_CYC = (SETTLE_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CNT_W    = 12;  // Holds base shifted by up to 7

  // ****************************************
  // Tuning engine states
  // ****************************************
  typedef enum logic [3:0] {
    PVC_ST_HOLD   = 4'b0001,  // Held or waiting to start
    PVC_ST_SETTLE = 4'b0010,  // Waiting for PLL to settle
    PVC_ST_DECIDE = 4'b0100,  // Judging one trim bit
    PVC_ST_DONE   = 4'b1000   // Finished or skipped
  } pvc_state_type;

endpackage

//--- hw/pvc_settle_timer.sv
`timescale 1ns/1ns
module pvc_settle_timer #(
  parameter int CNT_W    = 12,
  parameter int BASE_CYC = 16
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       load,
  input  wire logic [2:0] settle_select,
  output logic            expired
);

  // ****************************************
  // Wait length
  // ****************************************
  localparam logic [CNT_W-1:0] BASE = CNT_W'(BASE_CYC);  // Shortest wait

  logic [CNT_W-1:0] cnt_q;  // Remaining cycles
  logic [CNT_W-1:0] cnt_d;  // Next count
  wire  [CNT_W-1:0] limit;  // Wait for this select

  // Each select step doubles the wait
  assign limit   = BASE << settle_select;
  assign expired = (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1}) && !load;
  assign cnt_d   = load ? limit : (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;

  // Down counter
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

  property p_settle_load;
    @(posedge sys_clk) disable iff (rst)
    (ce && load) |=> (cnt_q == (BASE << $past(settle_select)));
  endproperty
  a_settle_load: assert property (p_settle_load) else $error("settle load wrong");

endmodule

//--- hw/pvc_top.sv
`timescale 1ns/1ns
// How it works
// - Seven-bit trim code, engine writes it automatically
// - Found trim reads back; host may restore
// - Releasing hold with enable starts tuning
// - Engine searches trim to centre oscillator
// - Settle field sets wait before each trim decision
// - Complete flag after finish or skipped tuning
// - Run bit resets high; low holds calibration
// - Run bit low also resets clock dividers
module pvc_top (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      osc_freq_high,
  output logic [7:0]                     reg_rdata,
  output logic                           synth_pll_hold,
  output logic [pvc_pkg::TRIM_W-1:0]     oscillator_trim_code,
  output logic                           osc_tune_busy,
  output logic                           osc_tune_complete,
  output logic                           converter_cal_hold,
  output logic                           digital_div_reset,
  output logic                           link_div_reset
);

  // ****************************************
  // Registers and state
  // ****************************************
  logic                              hold_q;        // PLL hold bit
  logic                              tune_en_q;     // Tune enable bit
  logic [pvc_pkg::SETTLE_W-1:0]      settle_q;      // Settle select field
  logic                              done_q;        // Tune complete flag
  logic                              done_d;        // Next complete flag
  logic                              cal_run_q;     // Calibration run bit
  logic [7:0]                        rdata_q;       // Registered read data
  logic                              busy_q;        // Engine running
  pvc_pkg::pvc_state_type            state_q;       // Engine state
  pvc_pkg::pvc_state_type            state_d;       // Next engine state
  logic [pvc_pkg::TRIM_W-1:0]        trim_code;     // Current trim code

  // ****************************************
  // Address decode
  // ****************************************
  wire wr_trim   = reg_wr && (reg_addr == pvc_pkg::ADDR_TRIM);
  wire wr_hold   = reg_wr && (reg_addr == pvc_pkg::ADDR_HOLD);
  wire wr_tctrl  = reg_wr && (reg_addr == pvc_pkg::ADDR_TCTRL);
  wire wr_calrun = reg_wr && (reg_addr == pvc_pkg::ADDR_CALRUN);

  // Engine handshakes
  wire in_hold   = (state_q == pvc_pkg::PVC_ST_HOLD);
  wire in_settle = (state_q == pvc_pkg::PVC_ST_SETTLE);
  wire in_decide = (state_q == pvc_pkg::PVC_ST_DECIDE);
  wire release_go = in_hold && !hold_q;               // Hold now released
  wire start     = release_go && tune_en_q;           // Begin a search
  wire search_last;                                   // Final trim bit
  wire settled;                                       // Settle wait over
  wire step      = in_decide;                         // Judge one bit
  wire load_wait = start || (in_decide && !search_last);
  wire busy_now  = in_settle || in_decide;
  // Host trim writes are dropped while the engine owns the code
  wire host_load = wr_trim && !busy_now;

  // ****************************************
  // Read mux
  // ****************************************
  wire [7:0] rd_trim   = {1'b0, trim_code};
  wire [7:0] rd_hold   = {7'h00, hold_q};
  wire [7:0] rd_tctrl  = {1'b0, settle_q, 3'h0, tune_en_q};
  wire [7:0] rd_tstat  = {7'h00, done_q};
  wire [7:0] rd_calrun = {7'h00, cal_run_q};
  wire [7:0] rd_mux    = (reg_addr == pvc_pkg::ADDR_TRIM)   ? rd_trim   :
                         (reg_addr == pvc_pkg::ADDR_HOLD)   ? rd_hold   :
                         (reg_addr == pvc_pkg::ADDR_TCTRL)  ? rd_tctrl  :
                         (reg_addr == pvc_pkg::ADDR_TSTAT)  ? rd_tstat  :
                         (reg_addr == pvc_pkg::ADDR_CALRUN) ? rd_calrun : 8'h00;

  // ****************************************
  // Settle timer and trim search
  // ****************************************
  pvc_settle_timer #(
    .CNT_W    (pvc_pkg::SETTLE_CNT_W),
    .BASE_CYC (pvc_pkg::SETTLE_BASE_CYC)
  ) pvc_settle_timer_inst (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .ce            (ce),
    .load          (load_wait),
    .settle_select (settle_q),
    .expired       (settled)
  );

  pvc_trim_search #(
    .W (pvc_pkg::TRIM_W)
  ) pvc_trim_search_inst (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .ce         (ce),
    .start      (start),
    .step       (step),
    .keep       (!osc_freq_high),
    .host_load  (host_load),
    .host_code  (reg_wdata[pvc_pkg::TRIM_LSB +: pvc_pkg::TRIM_W]),
    .reset_code (pvc_pkg::TRIM_RST),
    .code_q     (trim_code),
    .last       (search_last)
  );

  // ****************************************
  // Control registers
  // ****************************************
  // Host writable fields, reserved bits not stored
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hold_q    <= pvc_pkg::HOLD_RST;
      tune_en_q <= pvc_pkg::TUNE_EN_RST;
      settle_q  <= pvc_pkg::SETTLE_RST;
      cal_run_q <= pvc_pkg::CALRUN_RST;
    end else if (ce) begin
      if (wr_hold) begin
        hold_q <= reg_wdata[pvc_pkg::HOLD_BIT];
      end
      if (wr_tctrl) begin
        tune_en_q <= reg_wdata[pvc_pkg::TUNE_EN_BIT];
        settle_q  <= reg_wdata[pvc_pkg::SETTLE_LSB +: pvc_pkg::SETTLE_W];
      end
      if (wr_calrun) begin
        cal_run_q <= reg_wdata[pvc_pkg::CALRUN_BIT];
      end
    end
  end

  // Read data is captured on the read strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= pvc_pkg::RDATA_RST;
    end else if (ce && reg_rd) begin
      rdata_q <= rd_mux;
    end
  end

  // ****************************************
  // Tuning engine
  // ****************************************
  // Next state; hold always wins and restarts the engine
  always_comb begin
    state_d = state_q;
    case (state_q)
      pvc_pkg::PVC_ST_HOLD: begin
        if (start) begin
          state_d = pvc_pkg::PVC_ST_SETTLE;
        end else if (release_go) begin
          state_d = pvc_pkg::PVC_ST_DONE;
        end
      end
      pvc_pkg::PVC_ST_SETTLE: begin
        if (settled) begin
          state_d = pvc_pkg::PVC_ST_DECIDE;
        end
      end
      pvc_pkg::PVC_ST_DECIDE: begin
        if (search_last) begin
          state_d = pvc_pkg::PVC_ST_DONE;
        end else begin
          state_d = pvc_pkg::PVC_ST_SETTLE;
        end
      end
      pvc_pkg::PVC_ST_DONE: begin
        state_d = pvc_pkg::PVC_ST_DONE;
      end
      default: begin
        state_d = pvc_pkg::PVC_ST_HOLD;
      end
    endcase
    if (hold_q) begin
      state_d = pvc_pkg::PVC_ST_HOLD;
    end
  end

  // Complete flag: set on entering done, cleared under hold
  assign done_d = hold_q ? 1'b0 :
                  (state_d == pvc_pkg::PVC_ST_DONE);

  // Engine state and flags
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= pvc_pkg::PVC_ST_HOLD;
      done_q  <= 1'b0;
      busy_q  <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      done_q  <= done_d;
      busy_q  <= (state_d == pvc_pkg::PVC_ST_SETTLE) ||
                 (state_d == pvc_pkg::PVC_ST_DECIDE);
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata            = rdata_q;
  assign synth_pll_hold       = hold_q;
  assign oscillator_trim_code = trim_code;
  assign osc_tune_busy        = busy_q;
  assign osc_tune_complete    = done_q;
  assign converter_cal_hold   = !cal_run_q;
  // Dividers for the back end and the link held with calibration
  assign digital_div_reset    = !cal_run_q;
  assign link_div_reset       = !cal_run_q;

  // ****************************************
  // Checks
  // ****************************************
  property p_hold_clears;
    @(posedge sys_clk) disable iff (rst)
    (ce && hold_q) |=> !done_q && !busy_q;
  endproperty
  a_hold_clears: assert property (p_hold_clears) else $error("hold left flag set");

  property p_skip_done;
    @(posedge sys_clk) disable iff (rst)
    (ce && release_go && !tune_en_q) |=> done_q;
  endproperty
  a_skip_done: assert property (p_skip_done) else $error("skip not flagged");

  property p_start_run;
    @(posedge sys_clk) disable iff (rst)
    (ce && release_go && tune_en_q) |=> busy_q && !done_q && (trim_code == 7'h40);
  endproperty
  a_start_run: assert property (p_start_run) else $error("tuning did not start");

  property p_finish;
    @(posedge sys_clk) disable iff (rst)
    (ce && in_decide && search_last && !hold_q) |=> done_q && !busy_q;
  endproperty
  a_finish: assert property (p_finish) else $error("tuning did not finish");

  // Host trim write lands whenever the engine is idle, except in the cycle a search starts
  property p_host_trim;
    @(posedge sys_clk) disable iff (rst)
    (ce && host_load && !start) |=> (trim_code == $past(reg_wdata[6:0]));
  endproperty
  a_host_trim: assert property (p_host_trim) else $error("trim write lost");

  // Read returns the live trim code
  property p_readback;
    @(posedge sys_clk) disable iff (rst)
    (ce && reg_rd && (reg_addr == pvc_pkg::ADDR_TRIM)) |=> (reg_rdata == {1'b0, $past(trim_code)});
  endproperty
  a_readback: assert property (p_readback) else $error("trim readback wrong");

  property p_div_reset;
    @(posedge sys_clk) disable iff (rst)
    (ce && wr_calrun && !reg_wdata[0]) |=>
      digital_div_reset && link_div_reset && converter_cal_hold;
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("dividers not reset");

  property p_cal_run;
    @(posedge sys_clk) disable iff (rst)
    (ce && wr_calrun && reg_wdata[0]) |=> !converter_cal_hold && !digital_div_reset;
  endproperty
  a_cal_run: assert property (p_cal_run) else $error("calibration not run");

  // Settle field stored as written
  property p_settle_field;
    @(posedge sys_clk) disable iff (rst)
    (ce && wr_tctrl) |=> (settle_q == $past(reg_wdata[6:4]));
  endproperty
  a_settle_field: assert property (p_settle_field) else $error("settle field wrong");

  // Trim stays put while the PLL settles
  property p_trim_steady;
    @(posedge sys_clk) disable iff (rst)
    (ce && in_settle) |=> $stable(trim_code);
  endproperty
  a_trim_steady: assert property (p_trim_steady) else $error("trim moved in settle");

  // A non-final decision goes back to settling
  property p_decide_step;
    @(posedge sys_clk) disable iff (rst)
    (ce && in_decide && !search_last && !hold_q) |=> in_settle && busy_q && !done_q;
  endproperty
  a_decide_step: assert property (p_decide_step) else $error("search step wrong");

  // Complete flag holds until hold is set again
  property p_done_stays;
    @(posedge sys_clk) disable iff (rst)
    (ce && done_q && !hold_q) |=> done_q;
  endproperty
  a_done_stays: assert property (p_done_stays) else $error("complete flag dropped");

endmodule

//--- hw/pvc_trim_search.sv
`timescale 1ns/1ns
module pvc_trim_search #(
  parameter int W = 7
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         start,
  input  wire logic         step,
  input  wire logic         keep,
  input  wire logic         host_load,
  input  wire logic [W-1:0] host_code,
  input  wire logic [W-1:0] reset_code,
  output logic [W-1:0]      code_q,
  output logic              last
);

  // ****************************************
  // Successive approximation
  // ****************************************
  logic [W-1:0] bit_q;   // Bit under trial
  logic [W-1:0] code_d;  // Next code
  logic [W-1:0] bit_d;   // Next trial bit
  wire  [W-1:0] top;     // Midscale trial bit
  wire  [W-1:0] judged;  // Code with trial bit settled

  assign top    = {1'b1, {(W-1){1'b0}}};
  assign last   = bit_q[0];
  assign judged = keep ? code_q : (code_q & ~bit_q);

  // Start at midscale, then halve each step
  always_comb begin
    code_d = code_q;
    bit_d  = bit_q;
    if (start) begin
      code_d = top;
      bit_d  = top;
    end else if (step) begin
      code_d = judged | (bit_q >> 1);
      bit_d  = bit_q >> 1;
    end else if (host_load) begin
      code_d = host_code;
    end
  end

  // Code and pointer registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      code_q <= reset_code;
      bit_q  <= '0;
    end else if (ce) begin
      code_q <= code_d;
      bit_q  <= bit_d;
    end
  end

  property p_start_mid;
    @(posedge sys_clk) disable iff (rst)
    (ce && start) |=> (code_q == top) && (bit_q == top);
  endproperty
  a_start_mid: assert property (p_start_mid) else $error("search start wrong");

endmodule

//--- verif/pvc_top_tb.sv
`timescale 1ns/1ns
module pvc_top_tb;

  // ****************************************
  // Signals
  // ****************************************
  logic                          sys_clk;               // System clock
  logic                          rst;                   // Sync reset
  logic                          ce;                    // Clock enable
  logic                          reg_wr;                // Write strobe
  logic                          reg_rd;                // Read strobe
  logic [7:0]                    reg_addr;              // Register offset
  logic [7:0]                    reg_wdata;             // Write data
  logic                          osc_freq_high;         // Comparator model
  logic [7:0]                    reg_rdata;             // Read data
  logic                          synth_pll_hold;        // Hold bit out
  logic [pvc_pkg::TRIM_W-1:0]    oscillator_trim_code;  // Trim out
  logic                          osc_tune_busy;         // Engine running
  logic                          osc_tune_complete;     // Complete flag
  logic                          converter_cal_hold;    // Cal held
  logic                          digital_div_reset;     // Digital divider reset
  logic                          link_div_reset;        // Link divider reset
  logic [6:0]                    target;                // Oscillator centre code
  logic [7:0]                    rv;                    // Read result
  logic [6:0]                    saved;                 // Trim before freeze
  logic [6:0]                    tgt_tab [8];           // Targets per settle step
  int                            bad_count;             // Mismatches
  int                            compares;              // Comparisons made
  int                            cycle_count;           // Timeout counter
  int                            n;                     // Measured run length
  int                            len;                   // Expected run length
  logic [7:0]                    div_bits;              // Cal hold and divider resets

  assign div_bits = {5'h00, converter_cal_hold, digital_div_reset, link_div_reset};

  pvc_top pvc_top_inst (
    .sys_clk              (sys_clk),
    .rst                  (rst),
    .ce                   (ce),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .osc_freq_high        (osc_freq_high),
    .reg_rdata            (reg_rdata),
    .synth_pll_hold       (synth_pll_hold),
    .oscillator_trim_code (oscillator_trim_code),
    .osc_tune_busy        (osc_tune_busy),
    .osc_tune_complete    (osc_tune_complete),
    .converter_cal_hold   (converter_cal_hold),
    .digital_div_reset    (digital_div_reset),
    .link_div_reset       (link_div_reset)
  );

  // ****************************************
  // Clock, oscillator model, timeout
  // ****************************************
  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Oscillator runs fast when trim exceeds the centre code
  always @(posedge sys_clk) begin
    #1;
    osc_freq_high = (oscillator_trim_code > target);
  end

  // Cut a hang short
  always @(posedge sys_clk) begin
    cycle_count++;
    if (cycle_count == 60000) begin
      bad_count++;
      final_report();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  // Compare and count
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
  endtask

  // One register read, data lands at the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge sys_clk);
    #1;
    d      = reg_rdata;
    reg_rd = 1'b0;
  endtask

  // Idle cycles
  task automatic idle(input int k);
    repeat (k) begin
      @(posedge sys_clk);
      #1;
    end
  endtask

  // Bounded wait for the complete flag
  task automatic wait_done(input int limit, output int cnt);
    cnt = 0;
    while (osc_tune_complete !== 1'b1 && cnt < limit) begin
      @(posedge sys_clk);
      #1;
      cnt++;
    end
  endtask

  // Verdict and end of run
  task automatic final_report();
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    target = 7'h00;
    bad_count = 0;
    compares = 0;
    tgt_tab = '{7'h00, 7'h7F, 7'h40, 7'h3F, 7'h01, 7'h2B, 7'h55, 7'h6A};
    repeat (16) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    // Reset values and skipped tuning
    idle(2);
    rd(pvc_pkg::ADDR_HOLD, rv);
    check("hold reg", 8'h00, rv);
    rd(pvc_pkg::ADDR_TCTRL, rv);
    check("tune ctrl reg", 8'h40, rv);
    rd(pvc_pkg::ADDR_TSTAT, rv);
    check("status skipped", 8'h01, rv);
    rd(pvc_pkg::ADDR_CALRUN, rv);
    check("run reg", 8'h01, rv);
    rd(pvc_pkg::ADDR_TRIM, rv);
    check("trim reset", 8'h00, rv);
    check("div resets", 8'h00, div_bits);
    // Unmapped place
    wr(8'h60, 8'hFF);
    rd(8'h60, rv);
    check("unmapped", 8'h00, rv);
    // Full search at every settle select
    for (int s = 0; s < 8; s++) begin
      wr(pvc_pkg::ADDR_HOLD, 8'h01);
      idle(1);
      check("hold pin", 8'h01, {7'h00, synth_pll_hold});
      check("complete cleared", 8'h00, {7'h00, osc_tune_complete});
      wr(pvc_pkg::ADDR_TCTRL, {1'b0, 3'(s), 4'h1});
      target = tgt_tab[s];
      wr(pvc_pkg::ADDR_HOLD, 8'h00);
      idle(2);
      check("busy after release", 8'h01, {7'h00, osc_tune_busy});
      len = 7 * ((pvc_pkg::SETTLE_BASE_CYC << s) + 1);
      wait_done(len + 16, n);
      n = n + 2;
      compares++;
      if (n < len - 2 || n > len + 4) begin
        bad_count++;
        $display("[FAIL] run length expected %0d seen %0d", len, n);
      end
      rd(pvc_pkg::ADDR_TRIM, rv);
      check("found trim", {1'b0, target}, rv);
      check("trim pin", {1'b0, target}, {1'b0, oscillator_trim_code});
      rd(pvc_pkg::ADDR_TSTAT, rv);
      check("status done", 8'h01, rv);
      check("busy done", 8'h00, {7'h00, osc_tune_busy});
    end
    // Restore a stored trim with tuning off
    wr(pvc_pkg::ADDR_HOLD, 8'h01);
    wr(pvc_pkg::ADDR_TCTRL, 8'h40);
    wr(pvc_pkg::ADDR_TRIM, 8'h15);
    rd(pvc_pkg::ADDR_TRIM, rv);
    check("restored trim", 8'h15, rv);
    wr(pvc_pkg::ADDR_HOLD, 8'h00);
    wait_done(5, n);
    check("skip complete", 8'h01, {7'h00, osc_tune_complete});
    check("skip trim kept", 8'h15, {1'b0, oscillator_trim_code});
    // Freeze by clock enable mid-search, then abort by hold
    wr(pvc_pkg::ADDR_HOLD, 8'h01);
    wr(pvc_pkg::ADDR_TCTRL, 8'h01);
    target = 7'h22;
    wr(pvc_pkg::ADDR_HOLD, 8'h00);
    idle(40);
    check("busy running", 8'h01, {7'h00, osc_tune_busy});
    saved = oscillator_trim_code;
    ce = 1'b0;
    idle(20);
    check("frozen trim", {1'b0, saved}, {1'b0, oscillator_trim_code});
    check("frozen busy", 8'h01, {7'h00, osc_tune_busy});
    ce = 1'b1;
    wr(pvc_pkg::ADDR_HOLD, 8'h01);
    idle(2);
    check("abort busy", 8'h00, {7'h00, osc_tune_busy});
    check("abort complete", 8'h00, {7'h00, osc_tune_complete});
    // Calibration run bit and divider resets
    wr(pvc_pkg::ADDR_CALRUN, 8'h00);
    idle(1);
    check("held dividers", 8'h07, div_bits);
    rd(pvc_pkg::ADDR_CALRUN, rv);
    check("run cleared", 8'h00, rv);
    wr(pvc_pkg::ADDR_CALRUN, 8'h01);
    idle(1);
    check("run dividers", 8'h00, div_bits);
    final_report();
  end

endmodule
